// ### src/mac_periph_pkg.sv
// constants for the memory-mapped multiply-accumulate peripheral
`default_nettype none
package mac_periph_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // word addresses of the register map
  localparam logic [15:0] ADDR_UNSIGNED_OP = 16'h0130;
  localparam logic [15:0] ADDR_SIGNED_OP   = 16'h0132;
  localparam logic [15:0] ADDR_ACCUM_OP    = 16'h0134;
  localparam logic [15:0] ADDR_SECOND_OP   = 16'h0138;
  localparam logic [15:0] ADDR_RESULT_LO   = 16'h013a;
  localparam logic [15:0] ADDR_RESULT_HI   = 16'h013c;
  localparam logic [15:0] ADDR_RESULT_EXT  = 16'h013e;

  // extension register contents
  localparam logic [15:0] EXT_ZERO  = 16'h0000;
  localparam logic [15:0] EXT_ONES  = 16'hffff;
  localparam logic [15:0] EXT_CARRY = 16'h0001;

  // value on the read data port after reset and for unmapped reads
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_CLEAR  = 8'h00;

  typedef enum logic [1:0] {
    MODE_UNSIGNED,
    MODE_SIGNED,
    MODE_ACCUM
  } mode_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_FIRST_OP,
    REG_SECOND_OP,
    REG_RESULT_LO,
    REG_RESULT_HI,
    REG_RESULT_EXT
  } reg_sel_t;
endpackage
`default_nettype wire

// ### src/mac_arith.sv
// combinational multiply and accumulate arithmetic
`default_nettype none
module mac_arith
  import mac_periph_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic [W-1:0]   op_a_i,
  input  wire logic [W-1:0]   op_b_i,
  input  wire mode_t          mode_i,
  input  wire logic [2*W-1:0] acc_i,
  output logic      [2*W-1:0] sum_o,
  output logic      [W-1:0]   ext_o
);
  logic        [2*W-1:0] prod_u;
  logic        [2*W-1:0] prod_s;
  logic        [2*W:0]   acc_sum;
  logic signed [2*W-1:0] sx_a;
  logic signed [2*W-1:0] sx_b;

  assign prod_u = {{W{1'b0}}, op_a_i} * {{W{1'b0}}, op_b_i};
  // sign extend first so the product is formed at full width
  assign sx_a = {{W{op_a_i[W-1]}}, op_a_i}; // [RULE_12]
  assign sx_b = {{W{op_b_i[W-1]}}, op_b_i}; // [RULE_12]
  // two's complement product; the low 2W bits are exact
  assign prod_s = sx_a * sx_b;
  assign acc_sum = {1'b0, acc_i} + {1'b0, prod_u};

  always_comb begin
    case (mode_i)
      MODE_UNSIGNED: begin
        sum_o = prod_u;
        ext_o = EXT_ZERO; // [RULE_09]
      end
      MODE_SIGNED: begin
        sum_o = prod_s; // [RULE_12]
        ext_o = prod_s[2*W-1] ? EXT_ONES : EXT_ZERO; // [RULE_10]
      end
      MODE_ACCUM: begin
        sum_o = acc_sum[2*W-1:0]; // [RULE_11]
        ext_o = acc_sum[2*W] ? EXT_CARRY : EXT_ZERO; // [RULE_11]
      end
      default: begin
        sum_o = prod_u;
        ext_o = EXT_ZERO;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### src/mac_periph.sv
// peripheral multiply-accumulate unit with its register file
// Operation
// RULE_01: first operand address picks the mode
// RULE_02: first operand write only stores, never starts
// RULE_03: second operand write starts selected operation
// RULE_04: all results update at once, readable next
// RULE_05: host waits one slot for indirect reads
// RULE_06: low result holds bits 15..0, read/write
// RULE_07: high result holds bits 31..16
// RULE_08: extension register read-only, mode dependent
// RULE_09: unsigned mode extension always zero
// RULE_10: signed mode extension follows bit 31
// RULE_11: accumulate adds product, extension holds carry
// RULE_12: signed mode uses two's complement operands
// RULE_13: byte write to operand clears upper byte
// RULE_14: word registers, bytes reach lower byte only
// RULE_15: data registers keep contents across reset
// RULE_16: results hold until next second operand write
// RULE_17: host writes to result words replace them
`default_nettype none
module mac_periph
  import mac_periph_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned DW = DATA_W
) (
  input  wire logic          CLK_I,
  input  wire logic          RST_B_I,
  input  wire logic [AW-1:0] ADDR_I,
  input  wire logic          WR_I,
  input  wire logic          RD_I,
  input  wire logic          BYTE_I,
  input  wire logic [DW-1:0] WDATA_I,
  output logic      [DW-1:0] RDATA_O
);
  logic [DW-1:0]   first_op_ff;
  logic [DW-1:0]   second_op_ff;
  mode_t           mode_ff;
  logic [DW-1:0]   res_lo_ff;
  logic [DW-1:0]   res_hi_ff;
  logic [DW-1:0]   res_ext_ff;

  reg_sel_t        wr_sel;
  reg_sel_t        rd_sel;
  logic            wr_upper;
  logic            rd_upper;
  logic            start_op;
  logic [DW-1:0]   op_wdata;
  logic [DW-1:0]   nxt_second_op;
  logic [2*DW-1:0] calc_sum;
  logic [DW-1:0]   calc_ext;
  logic [DW-1:0]   nxt_rdata;

  // word decode, shared by the read and write paths
  function automatic reg_sel_t decode(input logic [AW-1:0] a);
    logic [AW-1:0] w;
    w = {a[AW-1:1], 1'b0};
    case (w)
      ADDR_UNSIGNED_OP: decode = REG_FIRST_OP;
      ADDR_SIGNED_OP:   decode = REG_FIRST_OP;
      ADDR_ACCUM_OP:    decode = REG_FIRST_OP;
      ADDR_SECOND_OP:   decode = REG_SECOND_OP;
      ADDR_RESULT_LO:   decode = REG_RESULT_LO;
      ADDR_RESULT_HI:   decode = REG_RESULT_HI;
      ADDR_RESULT_EXT:  decode = REG_RESULT_EXT;
      default:          decode = REG_NONE;
    endcase
  endfunction

  // byte write into a result word keeps its upper byte
  function automatic logic [DW-1:0] merge_low(input logic [DW-1:0] old,
                                              input logic [DW-1:0] d,
                                              input logic          byt);
    merge_low = byt ? {old[DW-1:8], d[7:0]} : d;
  endfunction

  assign wr_sel   = decode(ADDR_I);
  assign rd_sel   = decode(ADDR_I);
  // an odd byte address names no register: upper bytes are unreachable
  assign wr_upper = BYTE_I & ADDR_I[0]; // [RULE_14]
  assign rd_upper = BYTE_I & ADDR_I[0]; // [RULE_14]

  // operand byte writes behave like cpu registers
  assign op_wdata = BYTE_I ? {BYTE_CLEAR, WDATA_I[7:0]} : WDATA_I; // [RULE_13]

  assign start_op = WR_I & ~wr_upper & (wr_sel == REG_SECOND_OP); // [RULE_03]
  assign nxt_second_op = op_wdata;

  // product uses the operand being written, so results land in one edge
  mac_arith #(
    .W (DW)
  ) u_arith (
    .op_a_i (first_op_ff),
    .op_b_i (nxt_second_op),
    .mode_i (mode_ff),
    .acc_i  ({res_hi_ff, res_lo_ff}),
    .sum_o  (calc_sum),
    .ext_o  (calc_ext)
  );

  // operand and mode registers: no reset, contents survive it
  always_ff @(posedge CLK_I) begin // [RULE_15]
    if (WR_I && !wr_upper && wr_sel == REG_FIRST_OP) begin // [RULE_02]
      first_op_ff <= op_wdata;
      case ({ADDR_I[AW-1:1], 1'b0})
        ADDR_SIGNED_OP: mode_ff <= MODE_SIGNED; // [RULE_01]
        ADDR_ACCUM_OP:  mode_ff <= MODE_ACCUM; // [RULE_01]
        default:        mode_ff <= MODE_UNSIGNED; // [RULE_01]
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin // [RULE_15]
    if (start_op) begin
      second_op_ff <= nxt_second_op;
    end
  end

  // result words: start updates all three, host may overwrite lo/hi
  always_ff @(posedge CLK_I) begin // [RULE_15]
    if (start_op) begin
      res_lo_ff <= calc_sum[DW-1:0]; // [RULE_04] [RULE_06]
    end else if (WR_I && !wr_upper && wr_sel == REG_RESULT_LO) begin
      res_lo_ff <= merge_low(res_lo_ff, WDATA_I, BYTE_I); // [RULE_17]
    end
  end

  always_ff @(posedge CLK_I) begin // [RULE_15]
    if (start_op) begin
      res_hi_ff <= calc_sum[2*DW-1:DW]; // [RULE_04] [RULE_07]
    end else if (WR_I && !wr_upper && wr_sel == REG_RESULT_HI) begin
      res_hi_ff <= merge_low(res_hi_ff, WDATA_I, BYTE_I); // [RULE_17]
    end
  end

  // extension ignores host writes; otherwise held like the others
  always_ff @(posedge CLK_I) begin // [RULE_15]
    if (start_op) begin
      res_ext_ff <= calc_ext; // [RULE_04] [RULE_08]
    end
  end

  always_comb begin
    nxt_rdata = RDATA_RESET;
    if (RD_I && !rd_upper) begin
      case (rd_sel)
        REG_FIRST_OP:   nxt_rdata = first_op_ff;
        REG_SECOND_OP:  nxt_rdata = second_op_ff;
        REG_RESULT_LO:  nxt_rdata = res_lo_ff; // [RULE_16]
        REG_RESULT_HI:  nxt_rdata = res_hi_ff; // [RULE_16]
        REG_RESULT_EXT: nxt_rdata = res_ext_ff; // [RULE_08]
        default:        nxt_rdata = RDATA_RESET;
      endcase
      // byte reads see the lower byte only
      if (BYTE_I) begin // [RULE_14]
        nxt_rdata = {BYTE_CLEAR, nxt_rdata[7:0]};
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= RDATA_RESET;
    end else begin
      RDATA_O <= nxt_rdata;
    end
  end
endmodule
`default_nettype wire

// ### sim/mac_periph_props.sv
// port checker for the multiply-accumulate peripheral
`default_nettype none
module mac_periph_props
  import mac_periph_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  input wire logic [15:0] ADDR_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic        BYTE_I,
  input wire logic [15:0] WDATA_I,
  input wire logic [15:0] RDATA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic msb;
  assign msb = RDATA_O[15];
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence s_w(ad);
    WR_I && !BYTE_I && ADDR_I == ad;
  endsequence
  sequence s_r(ad);
    RD_I && !BYTE_I && ADDR_I == ad;
  endsequence
  sequence s_run(op);
    s_w(op) ##1 RD_I ##1 s_w(ADDR_SECOND_OP) ##1 s_r(ADDR_RESULT_LO);
  endsequence
  sequence s_all(op);
    s_run(op) ##1 s_r(ADDR_RESULT_HI) ##1 s_r(ADDR_RESULT_EXT);
  endsequence
  property p_lo;
    s_run(ADDR_UNSIGNED_OP) |=>
      RDATA_O == 16'($past(WDATA_I, 4) * $past(WDATA_I, 2));
  endproperty
  property p_uext;
    s_all(ADDR_UNSIGNED_OP) |=> RDATA_O == EXT_ZERO;
  endproperty
  property p_sext;
    s_all(ADDR_SIGNED_OP) |=> RDATA_O == {16{$past(msb)}};
  endproperty
  property p_cext;
    s_all(ADDR_ACCUM_OP) |=> RDATA_O[15:1] == 15'h0;
  endproperty
  property p_hold;
    s_r(ADDR_RESULT_LO) ##1 s_r(ADDR_RESULT_LO) |=> $stable(RDATA_O);
  endproperty
  // a write to the extension must leave it untouched
  property p_ro;
    s_r(ADDR_RESULT_EXT) ##1 WR_I && ADDR_I == ADDR_RESULT_EXT
      ##1 s_r(ADDR_RESULT_EXT) |=> RDATA_O == $past(RDATA_O, 2);
  endproperty
  property p_odd;
    RD_I && BYTE_I && ADDR_I[0] |=> RDATA_O == RDATA_RESET;
  endproperty
  property p_bhi;
    RD_I && BYTE_I |=> RDATA_O[15:8] == BYTE_CLEAR;
  endproperty
  a_lo: assert property (p_lo) else $error("low word wrong");
  a_uext: assert property (p_uext) else $error("ext not 0");
  a_sext: assert property (p_sext) else $error("ext sign");
  a_cext: assert property (p_cext) else $error("ext carry");
  a_hold: assert property (p_hold) else $error("not held");
  a_ro: assert property (p_ro) else $error("ext written");
  a_odd: assert property (p_odd) else $error("odd byte");
  a_bhi: assert property (p_bhi) else $error("byte upper");
endmodule
`default_nettype wire

// ### sim/cpu_bus_model.sv
// cpu core model issuing register accesses
`default_nettype none
module cpu_bus_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic      [15:0] addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic             byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, byte_o} = '0;
  end
  // direct addressing only, so no idle slot is owed
  task automatic acc(input logic w, r, input logic [15:0] a, d,
                     input logic b, output logic [15:0] q);
    wr_o = w;
    rd_o = r;
    addr_o = a;
    wdata_o = d;
    byte_o = b;
    @(negedge clk_i);
    q = rdata_i;
  endtask
  // released bus shows no stale value
  task automatic idle();
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### sim/mac_periph_test.sv
// self-checking bench for the multiply-accumulate peripheral
`default_nettype none
module mac_periph_test;
  import mac_periph_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        rst_b = 0;
  logic [15:0] ad, wd, rdt, q, a, b, x;
  logic        wr, rd, byt;
  logic [31:0] u, s;
  logic [32:0] e;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [31:0] tv [8] = '{32'h0000_0000, 32'h0001_0001, 32'h7fff_7fff,
    32'hffff_ffff, 32'h7fff_ffff, 32'h8000_7fff, 32'h8000_ffff,
    32'h8000_8000};
  initial forever #12.5 clk = ~clk;
  mac_periph u_dut (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(ad), .WR_I(wr),
    .RD_I(rd), .BYTE_I(byt), .WDATA_I(wd), .RDATA_O(rdt));
  cpu_bus_model u_cpu (.clk_i(clk), .rdata_i(rdt), .addr_o(ad),
    .wdata_o(wd), .wr_o(wr), .rd_o(rd), .byte_o(byt));
  task automatic w(input logic [15:0] ra, d, input logic bt = 1'b0);
    u_cpu.acc(1'b1, 1'b0, ra, d, bt, q);
  endtask
  task automatic rc(input logic [15:0] ra, xv, input logic bt = 1'b0);
    u_cpu.acc(1'b0, 1'b1, ra, 16'h0, bt, q);
    num_checks++;
    if (q !== xv) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, q, xv);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1;
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 8; i++) begin
        {a, b} = tv[i];
        w(ADDR_RESULT_LO, 16'h0000);
        w(ADDR_RESULT_HI, 16'hc000);
        w(ADDR_UNSIGNED_OP + 16'(2 * m), a);
        rc(ADDR_RESULT_HI, 16'hc000);
        w(ADDR_SECOND_OP, b);
        u = 32'(a) * 32'(b);
        s = $signed(a) * $signed(b);
        e = m == 2 ? 33'h0c0000000 + u : {1'b0, m == 1 ? s : u};
        x = m == 1 ? {16{s[31]}} : {15'h0, e[32]};
        rc(ADDR_RESULT_LO, e[15:0]);
        rc(ADDR_RESULT_HI, e[31:16]);
        rc(ADDR_RESULT_EXT, x);
      end
    end
    w(ADDR_RESULT_EXT, 16'h1234);
    rc(ADDR_RESULT_EXT, EXT_CARRY);
    rc(ADDR_RESULT_LO, 16'h0000);
    rc(ADDR_RESULT_LO, 16'h0000);
    w(ADDR_UNSIGNED_OP, 16'hab12, 1'b1);
    w(ADDR_SECOND_OP, 16'hff03, 1'b1);
    rc(ADDR_RESULT_LO, 16'h0036);
    rc(ADDR_RESULT_LO, 16'h0036);
    rc(ADDR_SIGNED_OP, 16'h0012);
    rc(ADDR_SECOND_OP, 16'h0003);
    w(ADDR_RESULT_HI, 16'ha5c3);
    rc(ADDR_RESULT_HI, 16'h00c3, 1'b1);
    rc(ADDR_RESULT_HI + 16'h1, 16'h0000, 1'b1);
    rc(16'h0140, RDATA_RESET);
    u_cpu.idle();
    rst_b = 0;
    @(negedge clk);
    rst_b = 1;
    rc(ADDR_RESULT_HI, 16'ha5c3);
    print_verdict();
  end
endmodule
bind mac_periph mac_periph_props u_props (.CLK_I(CLK_I),
  .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
  .BYTE_I(BYTE_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O));
`default_nettype wire
